/* File: hdl/fic_flash_iap_controller.sv */
// Flash programming controller with APB register file, unlock sequencer and operation timer.
`timescale 1ns/1ns
`default_nettype none
module fic_flash_iap_controller #(
    parameter int PROG_CYCLES_P = fic_pkg::PROG_CYCLES
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    output fic_pkg::fic_cmd_t    flash_cmd,
    output logic      [63:0]     flash_wdata,
    input  wire logic [15:0]     flash_rdata,
    output logic                 cpu_halt,
    output logic                 chip_reset_req
);
    import fic_pkg::*;

    //==========================================================================
    // Bus decode.
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] idx;
        idx = 4'hF;
        if (a[1:0] == 2'b00 && a < OFF_DATA_BASE + 8'(NUM_DATA_BYTES * 4)) begin
            idx = a[5:2];
        end
        return idx;
    endfunction

    function automatic logic mode_starts(input logic [2:0] m);
        return m == MODE_WRITE || m == MODE_ERASE || m == MODE_READ || m == MODE_UNLOCK;
    endfunction

    logic [7:0]  data_r [NUM_DATA_BYTES];
    logic [7:0]  addr_low_r;
    logic [3:0]  addr_high_r;
    logic [7:0]  chip_key_r;
    logic        ew_en_r;
    logic [2:0]  mode_r;
    logic        read_en_r;
    fic_state_t  st_r;
    fic_state_t  st_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [31:0] prdata_r;
    fic_cmd_t    cmd_r;
    logic        chip_rst_r;

    wire  [3:0]  idx      = reg_index(paddr);
    wire         mapped   = idx != 4'hF;
    wire         wr       = psel && penable && pwrite && mapped;
    wire         wr_ctrl  = wr && idx == OFF_MODE_CTRL[5:2];
    wire  [7:0]  wv       = pwdata[7:0];
    wire  [2:0]  wv_mode  = wv[BIT_MODE_HI:BIT_MODE_LO];
    wire         idle     = st_r == ST_IDLE;
    wire         all_three = wv[BIT_PROG_START] && wv[BIT_READ_EN] && wv[BIT_READ_START];
    wire  [11:0] word_addr = {addr_high_r, addr_low_r};

    //==========================================================================
    // Start decisions.
    wire go_unlock = wr_ctrl && idle && wv[BIT_UNLOCK] && wv_mode == MODE_UNLOCK;
    wire go_erase  = wr_ctrl && idle && wv[BIT_PROG_START] && !all_three
                     && wv_mode == MODE_ERASE && ew_en_r;
    wire go_prog   = wr_ctrl && idle && wv[BIT_PROG_START] && !all_three
                     && wv_mode == MODE_WRITE && ew_en_r;
    wire go_read   = wr_ctrl && idle && wv[BIT_READ_START] && !all_three
                     && wv_mode == MODE_READ && read_en_r;

    wire unlock_done = st_r == ST_UNLOCK && cnt_r == CNT_W'(UNLOCK_CYCLES - 1);
    wire op_done     = (st_r == ST_ERASE || st_r == ST_PROG)
                       && cnt_r == CNT_W'(PROG_CYCLES_P - 1);
    wire read_done   = st_r == ST_READ && cnt_r == CNT_W'(READ_CYCLES - 1);

    logic [NUM_DATA_BYTES-1:0] pat_hit;
    genvar g;
    generate
        for (g = 0; g < NUM_DATA_BYTES; g++) begin : g_pat
            assign pat_hit[g] = !UNLOCK_CHECK_MASK[g] || data_r[g] == UNLOCK_PAT[g];
        end
    endgenerate
    wire unlock_ok = unlock_done && &pat_hit;

    //==========================================================================
    // Sequencer.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (go_unlock) begin
                    st_nxt = ST_UNLOCK;
                end else if (go_erase) begin
                    st_nxt = ST_ERASE;
                end else if (go_prog) begin
                    st_nxt = ST_PROG;
                end else if (go_read) begin
                    st_nxt = ST_READ;
                end
            end
            ST_UNLOCK: if (unlock_done) begin
                st_nxt = ST_IDLE;
            end
            ST_ERASE, ST_PROG: if (op_done) begin
                st_nxt = ST_IDLE;
            end
            ST_READ: if (read_done) begin
                st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r  <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= (st_nxt != st_r || idle) ? '0 : cnt_r + 1'b1;
        end
    end

    //==========================================================================
    // Control register. The hardware set of the enabled bit beats a software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ew_en_r   <= 1'b0;
            mode_r    <= RST_MODE;
            read_en_r <= 1'b0;
        end else begin
            if (unlock_ok) begin
                ew_en_r <= 1'b1;
            end else if (wr_ctrl && !wv[BIT_EW_ENABLED]) begin
                ew_en_r <= 1'b0;
            end
            if (wr_ctrl && idle) begin
                mode_r    <= wv_mode;
                read_en_r <= wv[BIT_READ_EN];
            end
        end
    end

    //==========================================================================
    // Address, data and chip reset registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low_r  <= RST_BYTE;
            addr_high_r <= RST_BYTE[3:0];
            chip_key_r  <= RST_BYTE;
            chip_rst_r  <= 1'b0;
        end else begin
            if (wr && idx == OFF_ADDR_LOW[5:2]) begin
                addr_low_r <= wv;
            end
            if (wr && idx == OFF_ADDR_HIGH[5:2]) begin
                addr_high_r <= wv[3:0];
            end
            if (wr && idx == OFF_CHIP_RESET[5:2]) begin
                chip_key_r <= wv;
            end
            chip_rst_r <= wr && idx == OFF_CHIP_RESET[5:2] && wv == CHIP_RST_KEY;
        end
    end

    // A finished read loads word zero; it wins over a bus write in the same cycle.
    generate
        for (g = 0; g < NUM_DATA_BYTES; g++) begin : g_data
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    data_r[g] <= RST_BYTE;
                end else if (read_done && g < 2) begin
                    data_r[g] <= flash_rdata[8*(g%2) +: 8];
                end else if (wr && idx == 4'(OFF_DATA_BASE[5:2] + g)) begin
                    data_r[g] <= wv;
                end
            end
            assign flash_wdata[8*g +: 8] = data_r[g];
        end
    endgenerate

    //==========================================================================
    // Flash command strobes, one cycle at the start of each operation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= '0;
        end else begin
            cmd_r.erase   <= go_erase;
            cmd_r.prog    <= go_prog;
            cmd_r.read    <= go_read;
            if (go_erase) begin
                cmd_r.addr <= {word_addr[11:8], 8'h00};
            end else if (go_prog) begin
                cmd_r.addr <= {word_addr[11:2], 2'b00};
            end else if (go_read) begin
                cmd_r.addr <= word_addr;
            end
        end
    end

    //==========================================================================
    // Read data is captured in the setup phase so the access phase needs no wait.
    wire [7:0] ctrl_view = {ew_en_r, mode_r, st_r == ST_UNLOCK,
                            st_r == ST_ERASE || st_r == ST_PROG, read_en_r, st_r == ST_READ};
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (idx >= OFF_DATA_BASE[5:2] && mapped) begin
            rd_mux = data_r[3'(idx - OFF_DATA_BASE[5:2])];
        end else if (idx == OFF_MODE_CTRL[5:2]) begin
            rd_mux = ctrl_view;
        end else if (idx == OFF_CHIP_RESET[5:2]) begin
            rd_mux = chip_key_r;
        end else if (idx == OFF_ADDR_LOW[5:2]) begin
            rd_mux = addr_low_r;
        end else if (idx == OFF_ADDR_HIGH[5:2]) begin
            rd_mux = {4'h0, addr_high_r};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= {24'h000000, rd_mux};
        end
    end

    assign prdata         = prdata_r;
    assign pready         = 1'b1;
    assign pslverr        = psel && penable && !mapped;
    assign flash_cmd      = cmd_r;
    assign cpu_halt       = st_r == ST_ERASE || st_r == ST_PROG || st_r == ST_READ;
    assign chip_reset_req = chip_rst_r;

    //==========================================================================
    // Assertions.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_unlock_run;
        (st_r == ST_UNLOCK) [*8];
    endsequence

    sequence s_read_run;
        (st_r == ST_READ) [*3] ##1 (st_r == ST_IDLE);
    endsequence

    reserved_mode_a: assert property (
        wr_ctrl && idle && !mode_starts(wv_mode) |=> st_r == ST_IDLE)
        else $error("reserved mode started an operation");

    unlock_timer_a: assert property (
        go_unlock |=> s_unlock_run)
        else $error("unlock window ended early");

    unlock_end_a: assert property (
        unlock_done |=> st_r == ST_IDLE && !ctrl_view[BIT_UNLOCK])
        else $error("unlock trigger not cleared at expiry");

    unlock_pass_a: assert property (
        unlock_ok |=> ew_en_r)
        else $error("correct pattern did not enable erase and write");

    enable_set_a: assert property (
        $rose(ew_en_r) |-> $past(unlock_ok))
        else $error("enabled bit set without unlock");

    locked_guard_a: assert property (
        wr_ctrl && idle && wv[BIT_PROG_START] && !ew_en_r |=> st_r != ST_ERASE && st_r != ST_PROG)
        else $error("locked erase or write ran");

    read_refuse_a: assert property (
        wr_ctrl && !read_en_r |=> st_r != ST_READ)
        else $error("read ran while disabled");

    read_length_a: assert property (
        go_read |=> s_read_run)
        else $error("read busy length wrong");

    halt_cover_a: assert property (
        go_erase || go_prog |=> cpu_halt [*8])
        else $error("cpu not halted during operation");

    prog_hold_a: assert property (
        (st_r == ST_ERASE || st_r == ST_PROG) && !op_done |=> st_r == $past(st_r))
        else $error("operation ended before its time");

    prog_end_a: assert property (
        op_done |=> idle && !ctrl_view[BIT_PROG_START])
        else $error("busy bit not cleared at end");

    chip_reset_a: assert property (
        wr && idx == OFF_CHIP_RESET[5:2] && wv == CHIP_RST_KEY
        |=> chip_reset_req ##1 !chip_reset_req)
        else $error("chip reset pulse wrong");

    block_addr_a: assert property (
        cmd_r.erase |-> cmd_r.addr[7:0] == 8'h00)
        else $error("erase address not block aligned");

    high_zero_a: assert property (
        psel && !penable && !pwrite && idx == OFF_ADDR_HIGH[5:2] |=> prdata[7:4] == 4'h0)
        else $error("address high upper nibble not zero");

    erase_strobe_a: assert property (
        go_erase |=> flash_cmd.erase && cpu_halt)
        else $error("erase strobe or halt missing");

    prog_strobe_a: assert property (
        go_prog |=> flash_cmd.prog && cpu_halt)
        else $error("write strobe or halt missing");

    read_strobe_a: assert property (
        go_read |=> flash_cmd.read && flash_cmd.addr == $past(word_addr))
        else $error("read strobe or address wrong");

    strobe_once_a: assert property (
        flash_cmd.erase || flash_cmd.prog || flash_cmd.read
        |=> !(flash_cmd.erase || flash_cmd.prog || flash_cmd.read))
        else $error("command strobe longer than one cycle");

    triple_block_a: assert property (
        wr_ctrl && idle && all_three && wv_mode != MODE_UNLOCK |=> idle)
        else $error("triple start began an operation");

    unlock_mode_a: assert property (
        wr_ctrl && idle && wv[BIT_UNLOCK] && wv_mode != MODE_UNLOCK |=> st_r != ST_UNLOCK)
        else $error("unlock window opened outside unlock mode");

    enable_hold_a: assert property (
        ew_en_r && !wr_ctrl |=> ew_en_r)
        else $error("enabled bit dropped by itself");

    enable_clear_a: assert property (
        wr_ctrl && !wv[BIT_EW_ENABLED] && !unlock_ok |=> !ew_en_r)
        else $error("software clear of enabled bit lost");

    enable_stuck_a: assert property (
        !ew_en_r && !unlock_ok |=> !ew_en_r)
        else $error("enabled bit set by software");

    erase_addr_a: assert property (
        go_erase |=> flash_cmd.addr == {$past(addr_high_r), 8'h00})
        else $error("erase block address wrong");

    prog_addr_a: assert property (
        go_prog |=> flash_cmd.addr[11:2] == $past(word_addr[11:2]) && flash_cmd.addr[1:0] == 2'b00)
        else $error("write unit address wrong");

    read_load_a: assert property (
        read_done |=> data_r[0] == $past(flash_rdata[7:0]) && data_r[1] == $past(flash_rdata[15:8]))
        else $error("read word not loaded");

    busy_view_a: assert property (
        cpu_halt == (ctrl_view[BIT_PROG_START] || ctrl_view[BIT_READ_START]))
        else $error("halt differs from busy bits");

    low_addr_a: assert property (
        wr && idx == OFF_ADDR_LOW[5:2] |=> word_addr[7:0] == $past(wv))
        else $error("low address byte not stored");

    data_byte_a: assert property (
        wr && idx == 4'(OFF_DATA_BASE[5:2] + 7) |=> flash_wdata[63:56] == $past(wv))
        else $error("last data byte not stored");

    unlock_fail_a: assert property (
        unlock_done && !(&pat_hit) && !ew_en_r |=> !ew_en_r)
        else $error("wrong pattern enabled erase and write");

    reset_source_a: assert property (
        chip_reset_req |-> $past(wr && idx == OFF_CHIP_RESET[5:2] && wv == CHIP_RST_KEY))
        else $error("chip reset without key write");

    read_en_hold_a: assert property (
        !idle |=> read_en_r == $past(read_en_r))
        else $error("read enable changed while busy");

    unlock_count_a: assert property (
        st_r == ST_UNLOCK |-> cnt_r < CNT_W'(UNLOCK_CYCLES))
        else $error("unlock timer overran");

    prog_count_a: assert property (
        st_r == ST_ERASE || st_r == ST_PROG |-> cnt_r < CNT_W'(PROG_CYCLES_P))
        else $error("operation timer overran");

endmodule
`default_nettype wire

/* File: hdl/fic_pkg.sv */
// Package with register map, field layout and timing constants of the flash programming controller.
//==============================================================================
// Summary of operation
// - Mode field selects write, erase, read.
// - Unlock mode 110; reserved modes start nothing.
// - Trigger starts timer; timer expiry clears trigger.
// - Pattern 00/0D/C3 low, 04/09/40 high.
// - Correct pattern sets erase/write enabled bit.
// - Enabled bit ignores ones, accepts clearing.
// - Program start bit runs operation, reads busy.
// - Read refused while read enable low.
// - Read start reads word, clears when loaded.
// - CPU halted while accepted operation runs.
// - Writing 55H to reset register resets chip.
// - Twelve-bit address from low and high registers.
// - Upper nibble of high address reads zero.
// - Four sixteen-bit words as byte pairs.
// - Erase 256-word block; write aligned four words.
// - Erase or write lasts about 2.2 ms.
// - Erase and write rejected while not enabled.
package fic_pkg;

    //==========================================================================
    // Register byte addresses.
    localparam logic [7:0] OFF_MODE_CTRL  = 8'h00;
    localparam logic [7:0] OFF_CHIP_RESET = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW   = 8'h08;
    localparam logic [7:0] OFF_ADDR_HIGH  = 8'h0C;
    localparam logic [7:0] OFF_DATA_BASE  = 8'h10;
    localparam int         NUM_DATA_BYTES = 8;

    //==========================================================================
    // Mode control fields and reset values.
    localparam int BIT_EW_ENABLED = 7;
    localparam int BIT_MODE_HI    = 6;
    localparam int BIT_MODE_LO    = 4;
    localparam int BIT_UNLOCK     = 3;
    localparam int BIT_PROG_START = 2;
    localparam int BIT_READ_EN    = 1;
    localparam int BIT_READ_START = 0;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [2:0] RST_MODE     = 3'h0;
    localparam logic [7:0] CHIP_RST_KEY = 8'h55;

    //==========================================================================
    // Unlock pattern, by data byte index (word * 2 + high byte).
    localparam logic [7:0] UNLOCK_PAT [NUM_DATA_BYTES] =
        '{8'h00, 8'h00, 8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
    localparam logic [7:0] UNLOCK_CHECK_MASK = 8'hFC;

    //==========================================================================
    // Timing at a 100 ns clock.
    localparam int CLK_PERIOD_NS  = 100;
    localparam int PROG_TIME_NS   = 2200000;
    localparam int PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int UNLOCK_TIME_NS = 25600;
    localparam int UNLOCK_CYCLES  = UNLOCK_TIME_NS / CLK_PERIOD_NS;
    localparam int READ_CYCLES    = 3;
    localparam int CNT_W          = 15;

    //==========================================================================
    // Types.
    typedef enum logic [2:0] {
        MODE_WRITE  = 3'h0,
        MODE_ERASE  = 3'h1,
        MODE_READ   = 3'h3,
        MODE_UNLOCK = 3'h6
    } fic_mode_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_UNLOCK = 5'h02,
        ST_ERASE  = 5'h04,
        ST_PROG   = 5'h08,
        ST_READ   = 5'h10
    } fic_state_t;

    typedef struct packed {
        logic        erase;
        logic        prog;
        logic        read;
        logic [11:0] addr;
    } fic_cmd_t;

endpackage

/* File: verif/tb_fic_flash_iap_controller.sv */
// Self-checking testbench of the flash programming controller, driven over its register bus.
`timescale 1ns/1ns
`default_nettype none
module tb_fic_flash_iap_controller;
    import fic_pkg::*;

    //==========================================================================
    // Clock, reset and design ports.
    localparam int PROG_C = 20;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    fic_cmd_t          flash_cmd;
    logic [63:0]       flash_wdata;
    logic [15:0]       flash_rdata;
    logic              cpu_halt;
    logic              chip_reset_req;
    int                miscompares;
    int                cmp_count;
    int                starts;
    int                resets;
    int                halt_cnt;
    logic              last_err;
    logic [31:0]       v;
    logic [63:0]       exp_w;

    fic_flash_iap_controller #(.PROG_CYCLES_P(PROG_C)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_cmd(flash_cmd), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata), .cpu_halt(cpu_halt), .chip_reset_req(chip_reset_req)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Pulses are counted at the edge so that a one-cycle strobe is never missed.
    always @(posedge pclk) begin
        if (flash_cmd.erase === 1'b1 || flash_cmd.prog === 1'b1 || flash_cmd.read === 1'b1) begin
            starts++;
        end
        if (chip_reset_req === 1'b1) begin
            resets++;
        end
        if (cpu_halt === 1'b1) begin
            halt_cnt++;
        end
    end

    //==========================================================================
    // Bus and compare tasks.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        v        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // The pattern goes into words one to three; flip corrupts the last high byte.
    task automatic do_unlock(input logic [7:0] flip);
        logic [7:0] pat [6];
        pat = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
        apb(1'b1, OFF_MODE_CTRL, 32'h68);
        apb(1'b0, OFF_MODE_CTRL, 32'h0);
        chk("unlock_trigger", 32'h08, v & 32'h08);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, 8'(OFF_DATA_BASE + 4 * (k + 2)), {24'h0, pat[k] ^ (k == 5 ? flip : 8'h00)});
        end
        wait_cyc(280);
    endtask

    // Starts one operation and checks its strobe, address, stall length and busy bit.
    task automatic run_op(input logic [31:0] cmd, input int len, input logic [11:0] a);
        int s0;
        int h0;
        s0 = starts;
        h0 = halt_cnt;
        apb(1'b1, OFF_MODE_CTRL, cmd);
        if (len > 10) begin
            apb(1'b0, OFF_MODE_CTRL, 32'h0);
            chk("busy_flag", 32'h04, v & 32'h04);
        end
        wait_cyc(len + 5);
        chk("start_count", 32'(s0 + 1), 32'(starts));
        chk("op_addr", {20'h0, a}, {20'h0, flash_cmd.addr});
        chk("halt_ok", 32'h1, 32'((halt_cnt - h0 >= len) && (halt_cnt - h0 <= len + 1)));
        apb(1'b0, OFF_MODE_CTRL, 32'h0);
        chk("busy_clear", 32'h0, v & 32'h05);
    endtask

    task automatic results();
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        wait_cyc(20000);
        miscompares++;
        results();
    end

    //==========================================================================
    // Test sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        flash_rdata = 16'h0;
        {miscompares, cmp_count, starts, resets, halt_cnt} = '0;
        presetn = 1'b0;
        wait_cyc(20);
        presetn <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0);
            chk("reset_value", 32'h0, v);
        end
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, last_err});
        apb(1'b1, OFF_ADDR_HIGH, 32'hFF);
        apb(1'b0, OFF_ADDR_HIGH, 32'h0);
        chk("addr_high", 32'h0F, v);
        apb(1'b1, OFF_ADDR_LOW, 32'h57);
        apb(1'b1, OFF_ADDR_HIGH, 32'h0A);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 8'(OFF_DATA_BASE + 4 * k), 32'(8'h11 * (k + 1)));
            exp_w[8 * k +: 8] = 8'(8'h11 * (k + 1));
        end
        wait_cyc(2);
        chk("wdata", exp_w[31:0], flash_wdata[31:0]);
        chk("wdata_hi", exp_w[63:32], flash_wdata[63:32]);
        apb(1'b1, OFF_MODE_CTRL, 32'h80);
        apb(1'b0, OFF_MODE_CTRL, 32'h0);
        chk("enabled_set_sw", 32'h0, v & 32'h80);
        apb(1'b1, OFF_MODE_CTRL, 32'h14);
        wait_cyc(PROG_C + 5);
        chk("locked_erase", 32'h0, 32'(starts));
        do_unlock(8'h01);
        apb(1'b0, OFF_MODE_CTRL, 32'h0);
        chk("bad_pattern", 32'h0, v & 32'h88);
        do_unlock(8'h00);
        apb(1'b0, OFF_MODE_CTRL, 32'h0);
        chk("unlocked", 32'h80, v & 32'h88);
        run_op(32'h94, PROG_C, 12'hA00);
        apb(1'b1, OFF_MODE_CTRL, 32'hB2);
        run_op(32'hB3, READ_CYCLES, 12'hA57);
        apb(1'b0, OFF_DATA_BASE, 32'h0);
        chk("blank_check", 32'h0, v);
        run_op(32'h84, PROG_C, 12'hA54);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_MODE_CTRL, {24'h0, 1'b1, i == 0 ? 3'h2 : i == 1 ? 3'h4 : i == 2 ? 3'h5 : 3'h7, 4'h4});
            wait_cyc(PROG_C + 5);
            chk("reserved_mode", 32'h3, 32'(starts));
        end
        apb(1'b1, OFF_MODE_CTRL, 32'hB1);
        wait_cyc(5);
        chk("read_refused", 32'h3, 32'(starts));
        apb(1'b1, OFF_MODE_CTRL, 32'hB2);
        apb(1'b1, OFF_MODE_CTRL, 32'hB7);
        wait_cyc(PROG_C + 5);
        chk("triple_start", 32'h3, 32'(starts));
        flash_rdata <= 16'hBEEF;
        apb(1'b1, OFF_MODE_CTRL, 32'hB2);
        run_op(32'hB3, READ_CYCLES, 12'hA57);
        apb(1'b0, OFF_DATA_BASE, 32'h0);
        chk("read_low", 32'hEF, v);
        apb(1'b0, 8'(OFF_DATA_BASE + 4), 32'h0);
        chk("read_high", 32'hBE, v);
        apb(1'b1, OFF_MODE_CTRL, 32'h10);
        apb(1'b1, OFF_MODE_CTRL, 32'h14);
        wait_cyc(PROG_C + 5);
        chk("relocked", 32'h4, 32'(starts));
        apb(1'b1, OFF_CHIP_RESET, 32'h54);
        wait_cyc(3);
        chk("no_chip_reset", 32'h0, 32'(resets));
        apb(1'b1, OFF_CHIP_RESET, 32'h55);
        wait_cyc(3);
        chk("chip_reset", 32'h1, 32'(resets));
        results();
    end
endmodule
`default_nettype wire
